// *** logic/dso_params.svh ***
// Purpose: Register offsets, reset values and field positions of the output selector.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes:   Frequencies are held in units of 0.01 Hz.
`ifndef DSO_PARAMS_SVH
`define DSO_PARAMS_SVH

// Register byte offsets.
`define DSO_RELAY_SRC_OFS   8'h00
`define DSO_TRANS_SRC_OFS   8'h04
`define DSO_DET_FREQ_OFS    8'h08
`define DSO_DET_BAND_OFS    8'h0C
`define DSO_MONITOR_OFS     8'h10
`define DSO_IRQ_STATUS_OFS  8'h14
`define DSO_IRQ_MASK_OFS    8'h18

// Reset values.
`define DSO_RELAY_SRC_RST   5'h1D
`define DSO_TRANS_SRC_RST   5'h0E
`define DSO_DET_FREQ_RST    16'h0BB8
`define DSO_DET_BAND_RST    16'h03E8

// Field positions in monitor, status and mask registers.
`define DSO_RELAY_BIT       0
`define DSO_TRANS_BIT       1

// AXI response codes.
`define DSO_RESP_OKAY       2'h0
`define DSO_RESP_SLVERR     2'h2

`endif

// *** logic/dso_pkg.sv ***
// Purpose: Types shared by the output selector modules.
// Assumes: Source codes fit in five bits.
// Notes:   Codes not listed here select no output.
package dso_pkg;

  // Output source codes.
  typedef enum logic [4:0] {
    SRC_NONE       = 5'h00,
    SRC_FREQ_SET   = 5'h01,
    SRC_FREQ_MATCH = 5'h02,
    SRC_FREQ_WIN   = 5'h03,
    SRC_FREQ_THR   = 5'h04,
    SRC_OVERLOAD   = 5'h05,
    SRC_INV_OVL    = 5'h06,
    SRC_UNDERLOAD  = 5'h07,
    SRC_FAN_WARN   = 5'h08,
    SRC_STALL      = 5'h09,
    SRC_OVER_VOLT  = 5'h0A,
    SRC_LOW_VOLT   = 5'h0B,
    SRC_OVER_HEAT  = 5'h0C,
    SRC_LOST_CMD   = 5'h0D,
    SRC_RUN        = 5'h0E,
    SRC_TRIP       = 5'h1D
  } src_code_t;

  // Direction of the threshold detector, one-hot.
  typedef enum logic [2:0] {
    DIR_STEADY = 3'b001,
    DIR_ACCEL  = 3'b010,
    DIR_DECEL  = 3'b100
  } dir_t;

endpackage : dso_pkg

// *** logic/freq_detect.sv ***
// Purpose: Computes the four frequency-detection conditions.
// Assumes: All frequencies unsigned, same unit; inputs synchronous to clk_i.
// Notes:   The threshold condition holds its value while neither ramp is active.
module freq_detect
  import dso_pkg::*;
#(
  parameter int FW = 16  // Frequency word width.
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic [FW-1:0] set_freq_i,
  input  wire logic [FW-1:0] out_freq_i,
  input  wire logic [FW-1:0] op_freq_i,
  input  wire logic [FW-1:0] det_freq_i,
  input  wire logic [FW-1:0] det_band_i,
  input  wire logic          accel_i,
  input  wire logic          decel_i,
  output logic               freq_reached_set_o,
  output logic               freq_match_detect_o,
  output logic               freq_window_detect_o,
  output logic               freq_threshold_accel_decel_o
);

  // Absolute difference, used for three of the comparisons.
  function automatic logic [FW-1:0] abs_diff(input logic [FW-1:0] a, input logic [FW-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : abs_diff

  logic [FW-1:0] half_band;  // Half the detection band.
  logic          thr_now;    // Threshold condition for the present direction.
  logic          thr_held;   // Last threshold value, kept through steady running.
  dir_t          dir;        // Present ramp direction.

  assign half_band = det_band_i >> 1;

  assign freq_reached_set_o = abs_diff(set_freq_i, out_freq_i) < half_band;
  assign freq_match_detect_o = (abs_diff(set_freq_i, det_freq_i) < half_band)
                               && freq_reached_set_o;
  assign freq_window_detect_o = abs_diff(out_freq_i, op_freq_i) < half_band;

  // Acceleration wins if both ramp flags are raised together.
  always_comb begin
    if (accel_i) begin
      dir = DIR_ACCEL;
    end else if (decel_i) begin
      dir = DIR_DECEL;
    end else begin
      dir = DIR_STEADY;
    end
  end

  // accel decel threshold
  // The decel side is widened by one bit so op_freq_i plus half the band
  // cannot wrap the addition before the compare.
  always_comb begin
    case (dir)
      DIR_ACCEL: thr_now = op_freq_i >= det_freq_i;
      DIR_DECEL: thr_now = {1'b0, op_freq_i} + {1'b0, half_band} > {1'b0, det_freq_i};
      DIR_STEADY: thr_now = thr_held;
      default: thr_now = thr_held;
    endcase
  end

  // Remember the condition so a steady plateau keeps the last ramp's answer.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      thr_held <= 1'b0;
    end else begin
      thr_held <= thr_now;
    end
  end

  assign freq_threshold_accel_decel_o = thr_now;

endmodule : freq_detect

// *** logic/src_select.sv ***
// Purpose: Maps one source code onto one output level.
// Assumes: Condition inputs are already combined and synchronous.
// Notes:   Unknown codes select no output.
module src_select
  import dso_pkg::*;
(
  input  wire logic [4:0] code_i,
  input  wire logic [14:0] cond_i,  // Indexed by source code 0..14.
  input  wire logic       trip_i,
  output logic            level_o
);

  // source code decode
  // Codes 1 to 14 index the condition vector directly.
  always_comb begin
    case (code_i)
      SRC_NONE: level_o = 1'b0;
      SRC_TRIP: level_o = trip_i;
      default: begin
        if (code_i <= SRC_RUN) begin
          level_o = cond_i[code_i[3:0]];
        end else begin
          level_o = 1'b0;
        end
      end
    endcase
  end

endmodule : src_select

// *** logic/drive_status_output_select.sv ***
// Purpose: Selects drive conditions onto the relay and transistor outputs.
// Assumes: AXI4-Lite slave with 32-bit data; all inputs synchronous to clk_i.
// Notes:   Outputs and the monitor are registered one cycle after the conditions.
`include "dso_params.svh"

module drive_status_output_select
  import dso_pkg::*;
#(
  parameter int FW = 16  // Frequency word width.
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]    s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  // AXI4-Lite write response channel.
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  // AXI4-Lite read channels.
  input  wire logic [7:0]    s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  // Drive frequencies.
  input  wire logic [FW-1:0] set_freq_i,
  input  wire logic [FW-1:0] out_freq_i,
  input  wire logic [FW-1:0] op_freq_i,
  input  wire logic          accel_i,
  input  wire logic          decel_i,
  // Drive status conditions.
  input  wire logic          motor_overload_i,
  input  wire logic          inverse_time_overload_i,
  input  wire logic          underload_warn_i,
  input  wire logic          fan_warn_i,
  input  wire logic          stall_i,
  input  wire logic          dc_over_volt_i,
  input  wire logic          dc_low_volt_i,
  input  wire logic          over_heat_i,
  input  wire logic          analog_cmd_lost_i,
  input  wire logic          rs485_cmd_lost_i,
  input  wire logic          card_fitted_i,
  input  wire logic          card_comm_lost_i,
  input  wire logic          card_analog_lost_i,
  input  wire logic          run_cmd_i,
  input  wire logic          output_voltage_i,
  input  wire logic          dc_brake_i,
  input  wire logic          fault_trip_i,
  // Outputs toward the external load.
  output logic               relay_o,
  output logic               transistor_output_o,
  output logic               irq_o
);

  // Configuration and status registers.
  logic [4:0]    relay_src;          // Relay source code.
  logic [4:0]    trans_src;          // Transistor source code.
  logic [FW-1:0] detection_frequency;
  logic [FW-1:0] detection_band;
  logic [1:0]    irq_status;         // Sticky rising-edge events of each output.
  logic [1:0]    irq_mask;           // One enables the matching status bit.

  // Bus-side holding state.
  logic          aw_held;            // Write address accepted, waiting for data.
  logic          w_held;             // Write data accepted, waiting for address.
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          wr_go;              // Both halves present, commit this cycle.
  logic          rd_go;              // Read address taken this cycle.
  logic [31:0]   wr_old;             // Present value of the register being written.
  logic [31:0]   wr_word;            // That value with the enabled write bytes merged in.

  // Condition vector and selected levels.
  logic [14:0]   cond;
  logic          next_relay;
  logic          next_trans;
  logic [1:0]    rise;               // Output rising edges this cycle.
  logic [1:0]    w1c;                // Status bits cleared by software this cycle.

  // Merge a write word into an old value under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : merge

  // True when an address names a mapped register.
  function automatic logic mapped(input logic [7:0] addr);
    case (addr)
      `DSO_RELAY_SRC_OFS, `DSO_TRANS_SRC_OFS, `DSO_DET_FREQ_OFS, `DSO_DET_BAND_OFS,
      `DSO_MONITOR_OFS, `DSO_IRQ_STATUS_OFS, `DSO_IRQ_MASK_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // The frequency conditions for codes 1 to 4.
  freq_detect #(
    .FW (FW)
  ) u_freq_detect (
    .clk_i                        (clk_i),
    .rst_b_i                      (rst_b_i),
    .set_freq_i                   (set_freq_i),
    .out_freq_i                   (out_freq_i),
    .op_freq_i                    (op_freq_i),
    .det_freq_i                   (detection_frequency),
    .det_band_i                   (detection_band),
    .accel_i                      (accel_i),
    .decel_i                      (decel_i),
    .freq_reached_set_o           (cond[1]),
    .freq_match_detect_o          (cond[2]),
    .freq_window_detect_o         (cond[3]),
    .freq_threshold_accel_decel_o (cond[4])
  );

  // Status conditions indexed by their source code.
  assign cond[0]  = 1'b0;
  assign cond[5]  = motor_overload_i;
  assign cond[6]  = inverse_time_overload_i;
  assign cond[7]  = underload_warn_i;
  assign cond[8]  = fan_warn_i;
  assign cond[9]  = stall_i;
  assign cond[10] = dc_over_volt_i;
  assign cond[11] = dc_low_volt_i;
  assign cond[12] = over_heat_i;
  assign cond[13] = analog_cmd_lost_i | rs485_cmd_lost_i
                    | (card_fitted_i & (card_comm_lost_i | card_analog_lost_i));
  assign cond[14] = run_cmd_i & output_voltage_i & ~dc_brake_i;

  src_select u_relay_sel (
    .code_i  (relay_src),
    .cond_i  (cond),
    .trip_i  (fault_trip_i),
    .level_o (next_relay)
  );

  src_select u_trans_sel (
    .code_i  (trans_src),
    .cond_i  (cond),
    .trip_i  (fault_trip_i),
    .level_o (next_trans)
  );

  // Register the outputs so the external drivers never see decode glitches.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      relay_o             <= 1'b0;
      transistor_output_o <= 1'b0;
    end else begin
      relay_o             <= next_relay;
      transistor_output_o <= next_trans;
    end
  end

  // Rising edges of each output raise an event.
  assign rise[`DSO_RELAY_BIT] = next_relay & ~relay_o;
  assign rise[`DSO_TRANS_BIT] = next_trans & ~transistor_output_o;

  // Handshake outputs: each channel is free while nothing of its kind is pending.
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid_o;
  assign rd_go = s_axi_arvalid_i & s_axi_arready_o;

  // Capture write address and data independently, in either order.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `DSO_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= mapped(aw_addr) ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Old value of the addressed register, so lanes without a byte enable keep their bits.
  always_comb begin
    case (aw_addr)
      `DSO_RELAY_SRC_OFS: wr_old = {27'h0, relay_src};
      `DSO_TRANS_SRC_OFS: wr_old = {27'h0, trans_src};
      `DSO_DET_FREQ_OFS:  wr_old = 32'(detection_frequency);
      `DSO_DET_BAND_OFS:  wr_old = 32'(detection_band);
      `DSO_IRQ_MASK_OFS:  wr_old = {30'h0, irq_mask};
      default:            wr_old = 32'h0000_0000;
    endcase
  end

  // One shared merge, so each register only slices its own field out of it.
  assign wr_word = merge(wr_old, w_data, w_strb);

  // Configuration writes; the monitor register ignores writes.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      relay_src           <= `DSO_RELAY_SRC_RST;
      trans_src           <= `DSO_TRANS_SRC_RST;
      detection_frequency <= `DSO_DET_FREQ_RST;
      detection_band      <= `DSO_DET_BAND_RST;
      irq_mask            <= 2'h0;
    end else if (wr_go) begin
      case (aw_addr)
        `DSO_RELAY_SRC_OFS: relay_src           <= wr_word[4:0];
        `DSO_TRANS_SRC_OFS: trans_src           <= wr_word[4:0];
        `DSO_DET_FREQ_OFS:  detection_frequency <= wr_word[FW-1:0];
        `DSO_DET_BAND_OFS:  detection_band      <= wr_word[FW-1:0];
        `DSO_IRQ_MASK_OFS:  irq_mask            <= wr_word[1:0];
        default: begin
        end
      endcase
    end
  end

  // Write-one-to-clear only through the low byte lane.
  assign w1c = (wr_go && aw_addr == `DSO_IRQ_STATUS_OFS && w_strb[0]) ? w_data[1:0] : 2'h0;

  // Sticky events; a new edge in the clearing cycle is kept.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~w1c) | rise;
    end
  end

  // Level interrupt while any enabled event is pending.
  assign irq_o = |(irq_status & irq_mask);

  // Read path: data latched at the address handshake, held until taken.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `DSO_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= mapped(s_axi_araddr_i) ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
      case (s_axi_araddr_i)
        `DSO_RELAY_SRC_OFS:  s_axi_rdata_o <= {27'h0, relay_src};
        `DSO_TRANS_SRC_OFS:  s_axi_rdata_o <= {27'h0, trans_src};
        `DSO_DET_FREQ_OFS:   s_axi_rdata_o <= 32'(detection_frequency);
        `DSO_DET_BAND_OFS:   s_axi_rdata_o <= 32'(detection_band);
        `DSO_MONITOR_OFS:    s_axi_rdata_o <= {30'h0, transistor_output_o, relay_o};
        `DSO_IRQ_STATUS_OFS: s_axi_rdata_o <= {30'h0, irq_status};
        `DSO_IRQ_MASK_OFS:   s_axi_rdata_o <= {30'h0, irq_mask};
        default:             s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule : drive_status_output_select

// *** sim/dso_load.sv ***
// Purpose: External load on the relay contact and the open-collector output.
// Assumes: The open-collector node has a pull-up to the load supply.
// Notes:   The load only follows the block; it never drives back.
module dso_load (
  input  wire logic relay_i,
  input  wire logic transistor_i,
  output logic      contact_o,
  output logic      q_node_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The contact closes while the relay coil is energised.
  assign contact_o = relay_i;
  // The transistor sinks the node when on; otherwise the pull-up lifts it.
  assign q_node_o = transistor_i ? 1'b0 : 1'b1;
endmodule : dso_load

// *** sim/dso_chk.sv ***
// Purpose: Concurrent checks on the output selector ports.
// Assumes: Source codes stay at reset values until the first write address.
// Notes:   Bus checks follow the hand-over walk of each transfer.
module dso_chk (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        run_cmd_i,
  input wire logic        output_voltage_i,
  input wire logic        dc_brake_i,
  input wire logic        fault_trip_i,
  input wire logic        relay_o,
  input wire logic        transistor_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wrote;  // Set once a write address was taken; codes may differ after.
  // Tracks the first write, since the default checks only hold before it.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wrote <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      wrote <= 1'b1;
    end
  end
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_wr_done;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence
  property p_relay_dflt;
    !wrote |=> relay_o == $past(fault_trip_i);
  endproperty
  property p_trans_dflt;
    !wrote |=> transistor_output_o == $past(run_cmd_i && output_voltage_i && !dc_brake_i);
  endproperty
  property p_wr_answer;
    s_wr_take |=> s_wr_done;
  endproperty
  property p_b_release;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
  endproperty
  property p_rd_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  property p_r_release;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
  endproperty
  property p_ar_refuse;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  property p_aw_refuse;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_relay_dflt: assert property (p_relay_dflt)
    else $error("relay does not follow the trip input");
  a_trans_dflt: assert property (p_trans_dflt)
    else $error("transistor does not follow run with voltage");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_b_release: assert property (p_b_release)
    else $error("write response not released");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  a_r_release: assert property (p_r_release)
    else $error("read data not released");
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read address taken while data pending");
  a_aw_refuse: assert property (p_aw_refuse)
    else $error("write taken while response pending");
endmodule : dso_chk

// *** sim/tb_drive_status_output_select.sv ***
// Purpose: Self-checking bench for the output selector.
// Assumes: Full-word writes; frequencies in 0.01 Hz; default detection settings.
// Notes:   A watcher process checks each bus result against the oldest queued note.
`include "dso_params.svh"
module tb_drive_status_output_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_b_i = 1'b0, irq_exp = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, accel_i = 1'b0, decel_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, st = 32'h0;  // St bits 5 to 14 and 29 feed source code n; bits 15 to 20 feed codes 13 and 14.
  logic [3:0]  s_axi_wstrb_i = 4'hF;  // Whole words only.
  logic [15:0] set_freq_i = 16'h0, out_freq_i = 16'h0, op_freq_i = 16'h0, sf, of, pf;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic relay_o, transistor_output_o, irq_o, contact, q_node, c1, c2, c3, c4;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [40:0] nt;  // Read note: irq, address, data.
  logic [40:0] rq[$];
  logic [1:0]  wq[$];
  int n_mismatch = 0, compares = 0;
  int codes[11] = '{5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 29};
  logic [31:0] lost[4] = '{32'h8000, 32'h2_0000, 32'h3_0000, 32'h5_0000};
  logic [18:0] thr[6] = '{19'h6_0BB8, 19'h2_0BB7, 19'h5_09C5, 19'h1_09C4, 19'h6_0BB8, 19'h4_0000};
  wire motor_overload_i = st[5], inverse_time_overload_i = st[6], underload_warn_i = st[7];
  wire fan_warn_i = st[8], stall_i = st[9], dc_over_volt_i = st[10], dc_low_volt_i = st[11];
  wire over_heat_i = st[12], analog_cmd_lost_i = st[13], run_cmd_i = st[14];
  wire rs485_cmd_lost_i = st[15], card_fitted_i = st[16], card_comm_lost_i = st[17];
  wire card_analog_lost_i = st[18], output_voltage_i = st[19], dc_brake_i = st[20];
  wire fault_trip_i = st[29];
  drive_status_output_select dut_u (.*);
  dso_load load_u (.relay_i(relay_o), .transistor_i(transistor_output_o),
                   .contact_o(contact), .q_node_o(q_node));
  always #5 clk_i = ~clk_i;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // A wait that used up its bound ends the run.
  task automatic tmo(input int n);
    if (n >= 50) begin
      n_mismatch++;
      final_report();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    wq.push_back(r);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o && n < 50);
    s_axi_bready_i <= 1'b0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({irq_exp, a, d});
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 50);
    s_axi_rready_i <= 1'b0;
    tmo(n);
  endtask : rd
  // Applies status inputs, lets them settle, then reads the output monitor.
  task automatic mon(input logic [31:0] s, input logic [31:0] m);
    @(posedge clk_i);
    st <= s;
    repeat (2) @(posedge clk_i);
    rd(`DSO_MONITOR_OFS, m);
  endtask : mon
  function automatic logic near(input logic [15:0] x, input logic [15:0] y);
    return ((x > y) ? x - y : y - x) < 16'h01F4;
  endfunction : near
  // Watcher: each response taken is compared with the oldest note.
  always @(posedge clk_i) begin
    if (s_axi_bvalid_o && s_axi_bready_i) check(32'(s_axi_bresp_o), 32'(wq.pop_front()));
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      nt = rq.pop_front();
      check(s_axi_rdata_o, nt[31:0]);
      check(32'(s_axi_rresp_o), (nt[39:32] > 8'h18) ? 32'h2 : 32'h0);
      check(32'(irq_o), 32'(nt[40]));
      if (nt[39:32] == `DSO_MONITOR_OFS) check({30'h0, ~q_node, contact}, nt[31:0]);
    end
  end
  initial begin
    void'($urandom(32'hC0E9E29C));
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`DSO_RELAY_SRC_OFS, 32'h1D);
    rd(`DSO_TRANS_SRC_OFS, 32'h0E);
    rd(`DSO_DET_FREQ_OFS, 32'h0BB8);
    rd(`DSO_DET_BAND_OFS, 32'h03E8);
    rd(8'h1C, 32'h0);
    mon(32'h2000_0000, 32'h1);
    mon(32'h0008_4000, 32'h2);
    mon(32'h0018_4000, 32'h0);
    mon(32'h0000_4000, 32'h0);
    $display("test defaults done");
    foreach (codes[i]) begin
      wr(`DSO_RELAY_SRC_OFS, 32'(codes[i]), 2'h0);
      wr(`DSO_TRANS_SRC_OFS, 32'(codes[i]), 2'h0);
      mon((32'h1 << codes[i]) | ((codes[i] == 14) ? 32'h8_0000 : 32'h0), 32'h3);
      mon(32'h2000_7FE0 & ~(32'h1 << codes[i]), 32'h0);
    end
    wr(`DSO_RELAY_SRC_OFS, 32'h0D, 2'h0);
    wr(`DSO_TRANS_SRC_OFS, 32'h0D, 2'h0);
    foreach (lost[i]) mon(lost[i], (i == 1) ? 32'h0 : 32'h3);
    wr(`DSO_RELAY_SRC_OFS, 32'h0, 2'h0);
    wr(`DSO_TRANS_SRC_OFS, 32'h14, 2'h0);
    mon(32'hFFFF_FFFF, 32'h0);
    $display("test status codes done");
    for (int i = 0; i < 24; i++) begin
      if (i % 12 == 0) begin
        wr(`DSO_RELAY_SRC_OFS, (i == 0) ? 32'h1 : 32'h3, 2'h0);
        wr(`DSO_TRANS_SRC_OFS, (i == 0) ? 32'h2 : 32'h4, 2'h0);
      end
      sf = 16'(32'h09C4 + $urandom_range(1000));
      of = (i == 0) ? sf - 16'h01F4 : 16'(sf - 16'h0208 + $urandom_range(1040));
      pf = 16'(of - 16'h0208 + $urandom_range(1040));
      c1 = near(sf, of);
      c2 = near(sf, 16'h0BB8) && c1;
      c3 = near(of, pf);
      c4 = pf >= 16'h0BB8;
      @(posedge clk_i);
      set_freq_i <= sf;
      out_freq_i <= of;
      op_freq_i <= pf;
      accel_i <= 1'b1;
      mon(32'h0, (i < 12) ? {30'h0, c2, c1} : {30'h0, c4, c3});
    end
    wr(`DSO_RELAY_SRC_OFS, 32'h04, 2'h0);
    foreach (thr[i]) begin
      @(posedge clk_i);
      {accel_i, decel_i, op_freq_i} <= thr[i][17:0];
      mon(32'h0, thr[i][18] ? 32'h3 : 32'h0);
    end
    $display("test frequency done");
    wr(`DSO_RELAY_SRC_OFS, 32'h1D, 2'h0);
    wr(`DSO_TRANS_SRC_OFS, 32'h0E, 2'h0);
    wr(`DSO_IRQ_MASK_OFS, 32'h0, 2'h0);
    mon(32'h0, 32'h0);
    wr(`DSO_IRQ_STATUS_OFS, 32'h3, 2'h0);
    rd(`DSO_IRQ_STATUS_OFS, 32'h0);
    mon(32'h2000_0000, 32'h1);
    rd(`DSO_IRQ_STATUS_OFS, 32'h1);
    wr(`DSO_IRQ_MASK_OFS, 32'h1, 2'h0);
    irq_exp = 1'b1;
    rd(`DSO_IRQ_MASK_OFS, 32'h1);
    wr(`DSO_IRQ_STATUS_OFS, 32'h1, 2'h0);
    irq_exp = 1'b0;
    mon(32'h2008_4000, 32'h3);
    rd(`DSO_IRQ_STATUS_OFS, 32'h2);
    wr(`DSO_IRQ_MASK_OFS, 32'h3, 2'h0);
    irq_exp = 1'b1;
    wr(`DSO_MONITOR_OFS, 32'h0, 2'h0);
    rd(`DSO_MONITOR_OFS, 32'h3);
    wr(8'h1C, 32'h1, 2'h2);
    rd(`DSO_IRQ_STATUS_OFS, 32'h2);
    $display("test interrupt and bus done");
    final_report();
  end
endmodule : tb_drive_status_output_select
bind drive_status_output_select dso_chk chk_u (.*);
